// file: core/dual_serial_slave_port.sv
// Two-wire / synchronous serial slave port with its register map
// How it works
// [RL1] Command register always reads zero
// [RL2] Purge code pulses FIFO discard only
// [RL3] Restart code returns configuration to defaults
// [RL4] Chip-select high: two-wire; low: serial
// [RL5] Any chip-select low disables two-wire until reset
// [RL6] Address is 111011 plus serial-out level
// [RL7] Address bit sampled continuously
// [RL8] Standard, fast and high-speed two-wire rates
// [RL9] Two-wire write: address/data pairs until stop
// [RL10] Two-wire read: incrementing bytes until NACK
// [RL11] Clock level after select picks mode
// [RL12] Three-wire: data on serial-in, serial-out floats
// [RL13] Sample on rising, change on falling edge
// [RL14] Master frames transfers, clock steady
// [RL15] Control byte: bit 7 direction, 6:0 address
// [RL16] Serial write: control/data pairs until deselect
// [RL17] Read: dummy byte, then incrementing data
// [RL18] Select bit 0 four-wire, 1 three-wire
// [RL19] Watchdog times out two-wire after chosen period
// [RL20] Unknown command codes do nothing
// [RL21] Pins synchronised before use
`default_nettype none
module dual_serial_slave_port
  import serial_port_pkg::*;
#(
  parameter logic [8*CALIB_COUNT-1:0] CALIB_INIT       = '0,
  parameter logic [WDT_CNT_W-1:0]     WDT_SHORT_CYCLES = WDT_CNT_W'(WDT_SHORT_CYC),
  parameter logic [WDT_CNT_W-1:0]     WDT_LONG_CYCLES  = WDT_CNT_W'(WDT_LONG_CYC)
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic sck,
  input  wire logic chip_select_n,
  input  wire logic sdi_in,
  output logic      sdi_out,
  output logic      sdi_oe,
  input  wire logic sdo_in,
  output logic      sdo_out,
  output logic      sdo_oe,
  output logic      fifo_purge,
  output logic      soft_restart,
  output logic      spi_clock_mode,
  output logic      i2c_enabled
);

  port_state_t st;
  port_state_t next_st;

  // Register read map; unmapped addresses read zero
  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [2:0] c);
    logic [7:0] idx;
    idx = a - ADDR_CALIB_FIRST;
    if (a == ADDR_INTERFACE_CONFIG) begin
      read_reg = {5'h00, c};
    end else if (a >= ADDR_CALIB_FIRST && a <= ADDR_CALIB_LAST) begin
      read_reg = CALIB_INIT[{idx[5:0], 3'h0} +: 8];
    end else if (a == ADDR_CMD) begin
      read_reg = CMD_READ_VALUE; // RL1
    end else begin
      read_reg = 8'h00;
    end
  endfunction

  always_comb begin
    logic       sck_rise;
    logic       sck_fall;
    logic       spi_on;
    logic       i2c_on;
    logic       start;
    logic       stop;
    logic       wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd;
    logic [7:0] nb;
    logic [WDT_CNT_W-1:0] lim;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    spi_on   = 1'b0;
    i2c_on   = 1'b0;
    start    = 1'b0;
    stop     = 1'b0;
    wr_en    = 1'b0;
    wr_data  = 8'h00;
    rd       = 8'h00;
    nb       = 8'h00;
    lim      = '0;
    next_st  = st;

    // Pin synchronisers and edge detection
    next_st.s1 = {chip_select_n, sck, sdi_in, sdo_in}; // RL21
    next_st.s2 = st.s1; // RL21
    next_st.s3 = st.s2;
    next_st.purge   = 1'b0;
    next_st.restart = 1'b0;
    sck_rise = st.s2.sck & ~st.s3.sck; // RL8
    sck_fall = ~st.s2.sck & st.s3.sck;
    spi_on   = ~st.s2.chip_select_n; // RL4
    i2c_on   = st.i2c_ok & st.s2.chip_select_n; // RL4
    start    = i2c_on & st.s2.sck & st.s3.sck & st.s3.sdi & ~st.s2.sdi;
    stop     = i2c_on & st.s2.sck & st.s3.sck & ~st.s3.sdi & st.s2.sdi;
    rd       = read_reg(st.addr, st.cfg);
    nb       = {st.s_sh[6:0], st.s2.sdi};
    lim      = st.cfg[IF_WDT_SEL_BIT] ? WDT_LONG_CYCLES : WDT_SHORT_CYCLES;

    if (spi_on) begin
      next_st.i2c_ok = 1'b0; // RL5
    end

    // Two-wire slave
    if (!i2c_on) begin
      next_st.i_st    = I_IDLE;
      next_st.sda_low = 1'b0;
      next_st.wdt     = '0;
    end else if (start) begin
      next_st.i_st    = I_DEV;
      next_st.i_cnt   = 4'h0;
      next_st.sda_low = 1'b0;
      next_st.wdt     = '0;
    end else if (stop) begin
      next_st.i_st    = I_IDLE; // RL9
      next_st.sda_low = 1'b0;
      next_st.wdt     = '0;
    end else begin
      unique case (st.i_st)
        I_DEV, I_REG, I_DATA: begin
          if (sck_rise) begin
            next_st.i_sh  = {st.i_sh[6:0], st.s2.sdi};
            next_st.i_cnt = st.i_cnt + 4'h1;
          end else if (sck_fall && st.i_cnt == BITS_PER_BYTE) begin
            next_st.i_cnt   = 4'h0;
            next_st.i_st    = I_ACK;
            next_st.sda_low = 1'b1;
            if (st.i_st == I_DEV) begin
              next_st.i_next = st.i_sh[0] ? I_SEND : I_REG; // RL10
              if (st.i_sh[7:1] != {SLAVE_ADDR_HIGH, st.s2.sdo}) begin // RL6 RL7
                next_st.i_st    = I_IDLE;
                next_st.sda_low = 1'b0;
              end
            end else if (st.i_st == I_REG) begin
              next_st.addr   = st.i_sh;
              next_st.i_next = I_DATA;
            end else begin
              wr_en          = 1'b1; // RL9
              wr_data        = st.i_sh;
              next_st.i_next = I_REG;
            end
          end
        end
        I_ACK: begin
          if (sck_fall) begin
            next_st.i_st    = st.i_next;
            next_st.sda_low = 1'b0;
            if (st.i_next == I_SEND) begin
              next_st.i_sh    = rd; // RL10
              next_st.addr    = st.addr + 8'h01;
              next_st.sda_low = ~rd[7];
              next_st.i_cnt   = 4'h0;
            end
          end
        end
        I_SEND: begin
          if (sck_rise) begin
            next_st.i_cnt = st.i_cnt + 4'h1;
          end else if (sck_fall) begin
            if (st.i_cnt == BITS_PER_BYTE) begin
              next_st.i_st    = I_ACKM;
              next_st.sda_low = 1'b0;
            end else begin
              next_st.i_sh    = {st.i_sh[6:0], 1'b0};
              next_st.sda_low = ~st.i_sh[6];
            end
          end
        end
        I_ACKM: begin
          if (sck_rise) begin
            if (st.s2.sdi) begin
              next_st.i_st = I_IDLE; // RL10
            end else begin
              next_st.i_st   = I_ACK;
              next_st.i_next = I_SEND;
            end
          end
        end
        I_IDLE: begin
        end
        default: begin
          next_st.i_st = I_IDLE;
        end
      endcase
      // Bus watchdog on a stalled transfer
      if (!st.cfg[IF_WDT_EN_BIT] || st.i_st == I_IDLE || sck_rise || sck_fall) begin
        next_st.wdt = '0;
      end else if (st.wdt >= lim) begin
        next_st.i_st    = I_IDLE; // RL19
        next_st.sda_low = 1'b0;
        next_st.wdt     = '0;
      end else begin
        next_st.wdt = st.wdt + 1'b1;
      end
    end

    // Synchronous serial slave
    if (!spi_on) begin
      next_st.s_st  = S_CTRL; // RL14
      next_st.s_cnt = 3'h0;
      next_st.s_out = 8'h00;
    end else if (st.s3.chip_select_n) begin
      next_st.spi_mode = st.s2.sck; // RL11
      next_st.s_st     = S_CTRL;
      next_st.s_cnt    = 3'h0;
      next_st.s_out    = 8'h00;
    end else if (sck_rise) begin
      next_st.s_sh  = nb; // RL13
      next_st.s_cnt = st.s_cnt + 3'h1;
      if (st.s_cnt == 3'h7) begin
        unique case (st.s_st)
          S_CTRL: begin
            next_st.addr = {1'b0, nb[6:0]}; // RL15
            next_st.s_st = nb[SPI_RW_BIT] ? S_DUMMY : S_WDATA; // RL15
          end
          S_WDATA: begin
            wr_en        = 1'b1; // RL16
            wr_data      = nb;
            next_st.s_st = S_CTRL; // RL16
          end
          S_DUMMY: begin
            next_st.s_st = S_RDATA; // RL17
          end
          S_RDATA: begin
          end
        endcase
      end
    end else if (sck_fall && st.s_st == S_RDATA) begin
      if (st.s_cnt == 3'h0) begin
        next_st.s_out = rd; // RL13 RL17
        next_st.addr  = st.addr + 8'h01; // RL17
      end else begin
        next_st.s_out = {st.s_out[6:0], 1'b0}; // RL13
      end
    end

    // Register writes and commands
    if (wr_en) begin
      if (st.addr == ADDR_INTERFACE_CONFIG) begin
        next_st.cfg = wr_data[2:0];
      end else if (st.addr == ADDR_CMD) begin
        if (wr_data == CMD_PURGE) begin
          next_st.purge = 1'b1; // RL2
        end else if (wr_data == CMD_RESTART) begin
          next_st.restart = 1'b1; // RL3
          next_st.cfg     = INTERFACE_CONFIG_RESET; // RL3
        end
        // Other codes fall through untouched RL20
      end
    end

    // Pin drivers
    next_st.sdi_e = next_st.sda_low
                  | (spi_on & next_st.cfg[IF_THREE_WIRE_BIT] & next_st.s_st == S_RDATA); // RL12
    next_st.sdi_o = spi_on & next_st.s_out[7]; // RL12
    next_st.sdo_e = spi_on & ~next_st.cfg[IF_THREE_WIRE_BIT]; // RL12 RL18
    next_st.sdo_o = next_st.s_out[7];
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign sdi_out        = st.sdi_o;
  assign sdi_oe         = st.sdi_e;
  assign sdo_out        = st.sdo_o;
  assign sdo_oe         = st.sdo_e;
  assign fifo_purge     = st.purge;
  assign soft_restart   = st.restart;
  assign spi_clock_mode = st.spi_mode;
  assign i2c_enabled    = st.i2c_ok;

endmodule
`default_nettype wire

// file: core/serial_port_pkg.sv
// Constants, field layouts and state types of the dual serial slave port
`default_nettype none
package serial_port_pkg;
  localparam logic [7:0] ADDR_INTERFACE_CONFIG      = 8'h1A;
  localparam logic [7:0] ADDR_CALIB_FIRST  = 8'h30;
  localparam logic [7:0] ADDR_CALIB_LAST   = 8'h57;
  localparam logic [7:0] ADDR_CMD          = 8'h7E;
  localparam int         CALIB_COUNT       = 40;
  localparam logic [7:0] CMD_PURGE         = 8'hB0;
  localparam logic [7:0] CMD_RESTART       = 8'hB6;
  localparam logic [7:0] CMD_READ_VALUE    = 8'h00;
  localparam logic [5:0] SLAVE_ADDR_HIGH   = 6'h3B;
  localparam int         SPI_RW_BIT        = 7;
  localparam int         IF_THREE_WIRE_BIT = 0;
  localparam int         IF_WDT_EN_BIT     = 1;
  localparam int         IF_WDT_SEL_BIT    = 2;
  localparam logic [2:0] INTERFACE_CONFIG_RESET     = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
  localparam real        CLK_PERIOD_NS     = 4.0;
  localparam real        WDT_SHORT_MS      = 1.25;
  localparam real        WDT_LONG_MS       = 40.0;
  localparam int         WDT_CNT_W         = 24;
  localparam int         WDT_SHORT_CYC     = $rtoi(WDT_SHORT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int         WDT_LONG_CYC      = $rtoi(WDT_LONG_MS * 1.0e6 / CLK_PERIOD_NS);

  typedef struct packed {
    logic chip_select_n;
    logic sck;
    logic sdi;
    logic sdo;
  } pins_t;

  localparam pins_t PINS_IDLE = 4'hF;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_DEV  = 3'b001,
    I_REG  = 3'b010,
    I_DATA = 3'b011,
    I_ACK  = 3'b100,
    I_SEND = 3'b101,
    I_ACKM = 3'b110
  } i2c_state_t;

  typedef enum logic [1:0] {
    S_CTRL  = 2'b00,
    S_WDATA = 2'b01,
    S_DUMMY = 2'b10,
    S_RDATA = 2'b11
  } spi_state_t;

  typedef struct packed {
    pins_t                s1;
    pins_t                s2;
    pins_t                s3;
    logic                 i2c_ok;
    logic                 spi_mode;
    logic [2:0]           cfg;
    i2c_state_t           i_st;
    i2c_state_t           i_next;
    logic [3:0]           i_cnt;
    logic [7:0]           i_sh;
    logic                 sda_low;
    spi_state_t           s_st;
    logic [2:0]           s_cnt;
    logic [7:0]           s_sh;
    logic [7:0]           s_out;
    logic [7:0]           addr;
    logic [WDT_CNT_W-1:0] wdt;
    logic                 purge;
    logic                 restart;
    logic                 sdi_o;
    logic                 sdi_e;
    logic                 sdo_o;
    logic                 sdo_e;
  } port_state_t;

  localparam port_state_t STATE_RESET = '{
    s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE, i2c_ok: 1'b1, cfg: INTERFACE_CONFIG_RESET,
    i_st: I_IDLE, i_next: I_IDLE, s_st: S_CTRL, default: '0};
endpackage
`default_nettype wire

// file: verif/dual_serial_slave_port_bench.sv
// Self-checking bench for the dual serial slave port
`default_nettype none
module dual_serial_slave_port_bench import serial_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  function automatic logic [8*CALIB_COUNT-1:0] cal_pat();
    for (int i = 0; i < CALIB_COUNT; i++) begin
      cal_pat[8*i +: 8] = 8'hA0 + 8'(i);
    end
  endfunction
  localparam logic [8*CALIB_COUNT-1:0] CAL = cal_pat();

  logic sys_clk = 1'b0;
  logic resetn  = 1'b0;
  logic sck, cs_n, sdi_drv, sdi_en, sdi_out, sdi_oe, sdo_out, sdo_oe;
  logic fifo_purge, soft_restart, spi_clock_mode, i2c_enabled;
  int   fails = 0, checks = 0, n_purge = 0, n_restart = 0;
  logic [7:0] rx8;
  logic       ak;
  wire  sdi_line = sdi_oe ? sdi_out : (sdi_en ? sdi_drv : 1'b1);
  wire  sdo_line = sdo_oe ? sdo_out : 1'b0;

`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); \
  end \
end

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (fifo_purge === 1'b1) n_purge++;
    if (soft_restart === 1'b1) n_restart++;
  end

  dual_serial_slave_port #(.CALIB_INIT(CAL), .WDT_SHORT_CYCLES(24'h32),
    .WDT_LONG_CYCLES(24'hC8)) uut (.sys_clk(sys_clk), .resetn(resetn), .sck(sck),
    .chip_select_n(cs_n), .sdi_in(sdi_line), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
    .sdo_in(sdo_line), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .fifo_purge(fifo_purge),
    .soft_restart(soft_restart), .spi_clock_mode(spi_clock_mode),
    .i2c_enabled(i2c_enabled));

  serial_host_model host (.sys_clk(sys_clk), .sck(sck), .chip_select_n(cs_n),
    .sdi_drv(sdi_drv), .sdi_en(sdi_en), .sdi_line(sdi_line), .sdo_line(sdo_line));

  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic mode, input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rx;
    host.open_frame(mode);
    host.xfer({1'b0, a}, 1'b1, 1'b0, rx);
    host.xfer(d, 1'b1, 1'b0, rx);
    host.close_frame();
  endtask

  // Control byte, dummy byte, then two data bytes
  task automatic rd(input logic mode, input logic three, input logic [6:0] a,
                    input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] rx;
    host.open_frame(mode);
    host.xfer({1'b1, a}, 1'b1, three, rx);
    host.xfer(8'h00, !three, three, rx);
    host.xfer(8'h00, !three, three, rx);
    `CHK(rx, e0)
    host.xfer(8'h00, !three, three, rx);
    `CHK(rx, e1)
    host.close_frame();
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK(i2c_enabled, 1'b1)
    `CHK(spi_clock_mode, 1'b0)
    $display("test reset done");
    wr(1'b0, 7'h1A, 8'h06);
    `CHK(i2c_enabled, 1'b0)
    `CHK(spi_clock_mode, 1'b0)
    wr(1'b0, 7'h7E, 8'h55);
    rd(1'b0, 1'b0, 7'h7E, 8'h00, 8'h00);
    rd(1'b0, 1'b0, 7'h1A, 8'h06, 8'h00);
    $display("test mode 00 done");
    wr(1'b1, 7'h7E, CMD_PURGE);
    `CHK(spi_clock_mode, 1'b1)
    `CHK(n_purge, 1)
    `CHK(n_restart, 0)
    rd(1'b1, 1'b0, 7'h1A, 8'h06, 8'h00);
    wr(1'b1, 7'h1A, 8'h01);
    rd(1'b1, 1'b1, 7'h1A, 8'h01, 8'h00);
    $display("test mode 11 three-wire done");
    wr(1'b0, 7'h7E, CMD_RESTART);
    `CHK(n_restart, 1)
    rd(1'b0, 1'b0, 7'h1A, 8'h00, 8'h00);
    rd(1'b0, 1'b0, 7'h56, 8'hA0 + 8'h26, 8'hA0 + 8'h27);
    $display("test restart and burst done");
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK(i2c_enabled, 1'b1)
    host.i2c_start();
    host.i2c_byte(8'hEC, 1'b1, rx8, ak);
    `CHK(ak, 1'b0)
    host.i2c_byte(8'h1A, 1'b1, rx8, ak);
    `CHK(ak, 1'b0)
    host.i2c_byte(8'h04, 1'b1, rx8, ak);
    `CHK(ak, 1'b0)
    host.i2c_stop();
    host.i2c_start();
    host.i2c_byte(8'hEE, 1'b1, rx8, ak);
    `CHK(ak, 1'b1)
    host.i2c_stop();
    host.i2c_start();
    host.i2c_byte(8'hEC, 1'b1, rx8, ak);
    host.i2c_byte(8'h1A, 1'b1, rx8, ak);
    host.i2c_start();
    host.i2c_byte(8'hED, 1'b1, rx8, ak);
    `CHK(ak, 1'b0)
    host.i2c_byte(8'hFF, 1'b0, rx8, ak);
    `CHK(rx8, 8'h04)
    host.i2c_byte(8'hFF, 1'b1, rx8, ak);
    `CHK(rx8, 8'h00)
    host.i2c_stop();
    `CHK(i2c_enabled, 1'b1)
    $display("test two-wire done");
    close_out();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire

// file: verif/dual_serial_slave_port_sva.sv
// Concurrent checks on the dual serial slave port pins
`default_nettype none
module dual_serial_slave_port_sva (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic sdi_oe,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic fifo_purge,
  input wire logic soft_restart,
  input wire logic i2c_enabled
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  chk_purge_pulse: assert property (fifo_purge |=> !fifo_purge)
    else $error("purge pulse too long");
  chk_restart_pulse: assert property (soft_restart |=> !soft_restart)
    else $error("restart pulse too long");
  chk_pulse_apart: assert property (!(fifo_purge && soft_restart))
    else $error("purge and restart together");
  chk_select_locks: assert property ((!chip_select_n) [*6] |-> !i2c_enabled)
    else $error("two-wire still enabled after select");
  chk_lock_stays: assert property (!i2c_enabled |=> !i2c_enabled)
    else $error("two-wire enabled again without reset");
  chk_sdo_release: assert property (chip_select_n [*6] |-> !sdo_oe)
    else $error("serial-out driven while deselected");
  chk_sdi_quiet: assert property ((chip_select_n && !i2c_enabled) [*6] |-> !sdi_oe)
    else $error("data pin driven while idle");
  chk_sdo_on_fall: assert property ($rose(sck) |=> $stable(sdo_out) [*4])
    else $error("serial-out changed after rising clock");
endmodule

bind dual_serial_slave_port dual_serial_slave_port_sva chk (.sys_clk, .resetn, .sck,
  .chip_select_n, .sdi_oe, .sdo_out, .sdo_oe, .fifo_purge, .soft_restart, .i2c_enabled);
`default_nettype wire

// file: verif/serial_host_model.sv
// Host bus master driving the synchronous serial pins
`default_nettype none
module serial_host_model (
  input  wire logic sys_clk,
  output logic      sck           = 1'b0,
  output logic      chip_select_n = 1'b1,
  output logic      sdi_drv       = 1'b1,
  output logic      sdi_en        = 1'b0,
  input  wire logic sdi_line,
  input  wire logic sdo_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_lvl = 1'b0;

  // Half of the 160 ns link clock period
  task automatic half();
    repeat (20) @(posedge sys_clk);
  endtask

  task automatic open_frame(input logic mode);
    idle_lvl = mode;
    sck <= mode;
    half();
    chip_select_n <= 1'b0;
    half();
  endtask

  task automatic xfer(input logic [7:0] tx, input logic drive, input logic three,
                      output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      sdi_en <= drive;
      sdi_drv <= tx[i];
      half();
      rx[i] = three ? sdi_line : sdo_line;
      sck <= 1'b1;
      half();
    end
  endtask

  // Two-wire bit: data changes while the clock is low, sampled late in the high phase
  task automatic i2c_bit(input logic b, output logic r);
    sdi_drv <= 1'b0;
    sdi_en <= ~b;
    half();
    sck <= 1'b1;
    half();
    r = sdi_line;
    sck <= 1'b0;
    half();
  endtask

  task automatic i2c_start();
    sdi_en <= 1'b0;
    sck <= 1'b1;
    half();
    sdi_drv <= 1'b0;
    sdi_en <= 1'b1;
    half();
    sck <= 1'b0;
    half();
  endtask

  task automatic i2c_stop();
    sdi_drv <= 1'b0;
    sdi_en <= 1'b1;
    half();
    sck <= 1'b1;
    half();
    sdi_en <= 1'b0;
    half();
  endtask

  // Eight data bits then the acknowledge bit; a sent 1 releases the line
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(tx[i], rx[i]);
    end
    i2c_bit(ack_in, ack);
  endtask

  task automatic close_frame();
    sck <= idle_lvl;
    half();
    chip_select_n <= 1'b1;
    sdi_en <= 1'b0;
    half();
  endtask
endmodule
`default_nettype wire
